// >>> core/cfg_pkg.sv
// constants, register layout and the resolved-configuration carrier for cfg_select
// assumes a single clock domain; straps arrive as three-comparator thermometer codes
package cfg_pkg;
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 11;
  localparam int WORD_W   = 16;
  localparam int THERMO_W = 3;
  localparam int CODE_W   = 2;
  localparam int STRAPS   = 5;
  localparam int WB_AW    = 7;
  localparam int WB_DW    = 32;
  localparam int CNT_W    = 4;
  localparam int SYNC_W   = STRAPS * THERMO_W + 4;

  localparam logic [ADDR_W-1:0] ADDR_GLOBAL   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN  = 5'h0a;
  localparam logic [ADDR_W-1:0] ADDR_OVERRIDE = 5'h0d;
  localparam logic [ADDR_W-1:0] ADDR_STRAPREG = 5'h0e;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 5'h1f;

  localparam int BIT_SW_RST = 10;
  localparam int BIT_REF    = 5;
  localparam int BIT_GPD    = 0;
  localparam int CH_LSB     = 1;
  localparam int CH_W       = 4;
  localparam int PAT_LSB    = 5;
  localparam int PAT_W      = 3;
  localparam int BIT_OVRD   = 10;
  localparam int IF_LSB     = 0;
  localparam int SER_LSB    = 2;
  localparam int ORD_LSB    = 4;
  localparam int BIT_GAIN   = 6;

  localparam logic [DATA_W-1:0] REG_RESET = 11'h000;
  localparam logic [PAT_W-1:0]  PAT_SYNC   = 3'h1;
  localparam logic [PAT_W-1:0]  PAT_DESKEW = 3'h2;
  localparam logic [CNT_W-1:0]  LAST_BIT   = 4'hf;

  localparam logic [CODE_W-1:0] LVL_GND  = 2'h0;
  localparam logic [CODE_W-1:0] LVL_3_8  = 2'h1;
  localparam logic [CODE_W-1:0] LVL_5_8  = 2'h2;
  localparam logic [CODE_W-1:0] LVL_FULL = 2'h3;

  // strap index within the quantized array
  localparam int S_IF  = 0;
  localparam int S_SER = 1;
  localparam int S_RSV = 2;
  localparam int S_ORD = 3;
  localparam int S_SEN = 4;

  typedef struct packed {
    logic            two_lane;
    logic            ddr_clk;
    logic            ser_16x;
    logic            capture_rising;
    logic            lsb_first;
    logic            offset_binary;
    logic            gain_35db;
    logic            ref_internal;
    logic            pat_sync;
    logic            pat_deskew;
    logic            global_pd;
    logic [CH_W-1:0] chan_pd;
    logic            ref_pd;
    logic            pll_pd;
    logic            outbuf_pd;
  } cfg_t;
endpackage

// >>> core/cfg_select.sv
// cfg_select: resolves converter settings from four-level straps, pins and registers
// assumes straps come as thermometer codes from comparators; wishbone on clk
// Summary of operation
// - pin-only mode: configuration follows sampled straps from power-up, no reset needed
// - pin-only mode: serial pins are static configuration levels, not a port
// - register modes: serial pins form the port that writes internal registers
// - strap-carried settings follow registers only while override is high
// - power-down pin high forces global power-down; register bit acts when pin low
// - serial mode: coarse gain from register only with override, else 0 dB
// - serial mode: internal or external reference from register select bit
// - serial mode: sync/deskew patterns and power-down from register fields
// - pin mode: clock/data pins pick normal, sync, power-down or deskew
// - global power-down turns off channels, references, loop and output buffers
// - pin mode: select pin level picks reference and 0 or 3.5 dB gain
// - dedicated power-down input high forces power-down, low allows operation
// - first strap picks lane count and bit-clock rate; 3/8 level unused
// - second strap picks 14x/16x and capture edge for two-lane single-rate
// - fourth strap picks bit order and output data format
// - power-down pin applies automatically in every mode; straps apply unless override is high
// - combined mode honours straps and pin while accepting serial writes
// - software reset bit restores register defaults and clears itself
// - serial word is 16 bits: 5-bit address then 11 data bits
//
// Our own choices: the address map and the Wishbone slave port.
module cfg_select
  import cfg_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [THERMO_W-1:0] strap_interface_select,
  input  wire logic [THERMO_W-1:0] strap_serialization_select,
  input  wire logic [THERMO_W-1:0] strap_reserved,
  input  wire logic [THERMO_W-1:0] strap_order_format_select,
  input  wire logic [THERMO_W-1:0] serial_select_pin,
  input  wire logic                serial_clock_pin,
  input  wire logic                serial_input_pin,
  input  wire logic                power_down_pin,
  input  wire logic                hw_reset_pin,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [WB_DW-1:0]    wb_dat_i,
  output logic      [WB_DW-1:0]    wb_dat_o,
  output logic                     wb_ack_o,
  output cfg_t                     cfg_out
);

  // thermometer to level code
  function automatic logic [CODE_W-1:0] quantize(input logic [THERMO_W-1:0] t);
    if (t[2])
      return LVL_FULL;
    else if (t[1])
      return LVL_5_8;
    else if (t[0])
      return LVL_3_8;
    else
      return LVL_GND;
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] val,
                                              input logic [DATA_W-1:0] mask);
    return (old & ~mask) | (val & mask);
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic              sclk_q;
  logic [SYNC_W-1:0] next_sync1;
  logic [SYNC_W-1:0] next_sync2;
  logic              next_sclk_q;

  always_comb begin
    next_sync1  = {hw_reset_pin, power_down_pin, serial_input_pin, serial_clock_pin,
                   serial_select_pin, strap_order_format_select, strap_reserved,
                   strap_serialization_select, strap_interface_select};
    next_sync2  = sync1;
    next_sclk_q = sync2[SYNC_W-4];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1  <= '0;
      sync2  <= '0;
      sclk_q <= 1'b0;
    end else begin
      sync1  <= next_sync1;
      sync2  <= next_sync2;
      sclk_q <= next_sclk_q;
    end
  end

  logic [CODE_W-1:0] lvl [STRAPS];
  logic              sclk_s;
  logic              serial_input_pin_s;
  logic              pdn_s;
  logic              pin_only;
  logic              sel_s;

  genvar gi;
  generate
    for (gi = 0; gi < STRAPS; gi++) begin : g_quant
      assign lvl[gi] = quantize(sync2[gi*THERMO_W +: THERMO_W]);
    end
  endgenerate

  assign sclk_s   = sync2[SYNC_W-4];
  assign serial_input_pin_s  = sync2[SYNC_W-3];
  assign pdn_s    = sync2[SYNC_W-2];
  // reset pin held high selects pin-only control
  assign pin_only = sync2[SYNC_W-1];
  // digital level of the select pin is the mid comparator
  assign sel_s    = sync2[S_SEN*THERMO_W+1];

  // ---------------- serial port ----------------
  logic [WORD_W-2:0] shift;
  logic [CNT_W-1:0]  bit_cnt;
  logic [WORD_W-2:0] next_shift;
  logic [CNT_W-1:0]  next_bit_cnt;
  logic              ser_active;
  logic              sclk_fall;
  logic              ser_done;
  logic [WORD_W-1:0] ser_word;

  assign ser_active = !pin_only && !sel_s;
  assign sclk_fall  = sclk_q && !sclk_s;
  assign ser_done   = ser_active && sclk_fall && (bit_cnt == LAST_BIT);
  assign ser_word   = {shift, serial_input_pin_s};

  always_comb begin
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    if (!ser_active) begin
      // partial word dropped when select goes high
      next_bit_cnt = '0;
    end else if (sclk_fall) begin
      next_shift   = {shift[WORD_W-3:0], serial_input_pin_s};
      next_bit_cnt = bit_cnt + 1'b1; // wraps: words back to back
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else begin
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ---------------- register file ----------------
  logic [DATA_W-1:0] reg_global;
  logic [DATA_W-1:0] reg_pattern;
  logic [DATA_W-1:0] reg_override;
  logic [DATA_W-1:0] reg_strap;
  logic [DATA_W-1:0] next_global;
  logic [DATA_W-1:0] next_pattern;
  logic [DATA_W-1:0] next_override;
  logic [DATA_W-1:0] next_strap;
  logic              wb_req;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] wr_mask;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    next_global   = reg_global;
    next_pattern  = reg_pattern;
    next_override = reg_override;
    next_strap    = reg_strap;
    wr_en         = 1'b0;
    wr_addr       = '0;
    wr_data       = '0;
    wr_mask       = '0;
    // serial word wins a same-cycle collision with a bus write
    if (ser_done) begin
      wr_en   = 1'b1;
      wr_addr = ser_word[WORD_W-1 -: ADDR_W];
      wr_data = ser_word[DATA_W-1:0];
      wr_mask = '1;
    end else if (wb_req && wb_we_i) begin
      wr_en   = 1'b1;
      wr_addr = wb_adr_i[WB_AW-1:2];
      wr_data = wb_dat_i[DATA_W-1:0];
      wr_mask = {{(DATA_W-8){wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end
    if (wr_en) begin
      case (wr_addr)
        ADDR_GLOBAL: begin
          if (wr_data[BIT_SW_RST] && wr_mask[BIT_SW_RST]) begin
            // bit never stored, so it reads back low
            next_global   = REG_RESET;
            next_pattern  = REG_RESET;
            next_override = REG_RESET;
            next_strap    = REG_RESET;
          end else begin
            next_global = merge(reg_global, wr_data, wr_mask);
          end
        end
        ADDR_PATTERN:  next_pattern  = merge(reg_pattern, wr_data, wr_mask);
        ADDR_OVERRIDE: next_override = merge(reg_override, wr_data, wr_mask);
        ADDR_STRAPREG: next_strap    = merge(reg_strap, wr_data, wr_mask);
        default: ;
      endcase
    end
    // reset pin high (pulse, or held in pin-only mode) keeps defaults
    if (pin_only) begin
      next_global   = REG_RESET;
      next_pattern  = REG_RESET;
      next_override = REG_RESET;
      next_strap    = REG_RESET;
    end
    next_global[BIT_SW_RST] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_global   <= REG_RESET;
      reg_pattern  <= REG_RESET;
      reg_override <= REG_RESET;
      reg_strap    <= REG_RESET;
    end else begin
      reg_global   <= next_global;
      reg_pattern  <= next_pattern;
      reg_override <= next_override;
      reg_strap    <= next_strap;
    end
  end

  // ---------------- resolution ----------------
  cfg_t              next_cfg;
  logic              ovrd;
  logic [CODE_W-1:0] if_code;
  logic [CODE_W-1:0] ser_code;
  logic [CODE_W-1:0] ord_code;
  logic              edge_rise;
  logic [PAT_W-1:0]  pat;

  assign ovrd = reg_override[BIT_OVRD];
  assign pat  = reg_pattern[PAT_LSB +: PAT_W];

  always_comb begin
    next_cfg = '0;
    // reserved strap level is never looked at
    if_code  = ovrd ? reg_strap[IF_LSB +: CODE_W]  : lvl[S_IF];
    ser_code = ovrd ? reg_strap[SER_LSB +: CODE_W] : lvl[S_SER];
    ord_code = ovrd ? reg_strap[ORD_LSB +: CODE_W] : lvl[S_ORD];
    // unused interface level falls back to one-lane double rate
    next_cfg.two_lane = (if_code == LVL_5_8) || (if_code == LVL_FULL);
    next_cfg.ddr_clk  = (if_code != LVL_5_8);
    next_cfg.ser_16x  = (ser_code == LVL_3_8) || (ser_code == LVL_5_8);
    edge_rise         = (ser_code == LVL_5_8) || (ser_code == LVL_FULL);
    next_cfg.capture_rising = edge_rise && next_cfg.two_lane && !next_cfg.ddr_clk;
    next_cfg.lsb_first      = (ord_code == LVL_5_8) || (ord_code == LVL_FULL);
    next_cfg.offset_binary  = (ord_code == LVL_3_8) || (ord_code == LVL_5_8);
    if (pin_only) begin
      next_cfg.ref_internal = (lvl[S_SEN] == LVL_5_8) || (lvl[S_SEN] == LVL_FULL);
      next_cfg.gain_35db    = (lvl[S_SEN] == LVL_3_8) || (lvl[S_SEN] == LVL_5_8);
      next_cfg.pat_sync     = !sclk_s && serial_input_pin_s;
      next_cfg.pat_deskew   = sclk_s && serial_input_pin_s;
      next_cfg.global_pd    = pdn_s || (sclk_s && !serial_input_pin_s);
    end else begin
      next_cfg.ref_internal = reg_global[BIT_REF];
      next_cfg.gain_35db    = ovrd && reg_strap[BIT_GAIN];
      next_cfg.pat_sync     = (pat == PAT_SYNC);
      next_cfg.pat_deskew   = (pat == PAT_DESKEW);
      next_cfg.global_pd    = pdn_s || reg_global[BIT_GPD];
      next_cfg.chan_pd      = reg_global[CH_LSB +: CH_W];
    end
    if (next_cfg.global_pd) begin
      next_cfg.chan_pd = '1;
    end
    next_cfg.ref_pd    = next_cfg.global_pd;
    next_cfg.pll_pd    = next_cfg.global_pd;
    next_cfg.outbuf_pd = next_cfg.global_pd;
  end

  // ---------------- wishbone slave ----------------
  logic [WB_DW-1:0] next_dat;
  logic             next_ack;

  always_comb begin
    next_ack = wb_req;
    next_dat = '0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i[WB_AW-1:2])
        ADDR_GLOBAL:   next_dat = {{(WB_DW-DATA_W){1'b0}}, reg_global};
        ADDR_PATTERN:  next_dat = {{(WB_DW-DATA_W){1'b0}}, reg_pattern};
        ADDR_OVERRIDE: next_dat = {{(WB_DW-DATA_W){1'b0}}, reg_override};
        ADDR_STRAPREG: next_dat = {{(WB_DW-DATA_W){1'b0}}, reg_strap};
        ADDR_STATUS:   next_dat = {{(WB_DW-$bits(cfg_t)){1'b0}}, cfg_out};
        default:       next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      cfg_out  <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      cfg_out  <= next_cfg;
    end
  end

endmodule

// >>> test/cfg_board_model.sv
// cfg_board_model: strap resistors, static pins and a bit-banged serial host
// assumes tasks are entered just after a rising edge of clk
module cfg_board_model
  import cfg_pkg::*;
(
  input  wire logic                clk,
  output logic      [THERMO_W-1:0] strap_interface_select,
  output logic      [THERMO_W-1:0] strap_serialization_select,
  output logic      [THERMO_W-1:0] strap_reserved,
  output logic      [THERMO_W-1:0] strap_order_format_select,
  output logic      [THERMO_W-1:0] serial_select_pin,
  output logic                     serial_clock_pin,
  output logic                     serial_input_pin,
  output logic                     power_down_pin,
  output logic                     hw_reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {strap_interface_select, strap_serialization_select, strap_order_format_select} = '0;
    strap_reserved = '0;
    serial_select_pin = '1;
    {serial_clock_pin, serial_input_pin, power_down_pin, hw_reset_pin} = 4'h1;
  end
  // st = {interface, serialization, order, select}; lv = {pd, sclk, serial_input_pin, hw reset}
  task automatic pins(input logic [4*THERMO_W-1:0] st, input logic [3:0] lv);
    {strap_interface_select, strap_serialization_select} <= st[11:6];
    {strap_order_format_select, serial_select_pin} <= st[5:0];
    {power_down_pin, serial_clock_pin, serial_input_pin, hw_reset_pin} <= lv;
    repeat (6) @(posedge clk);
  endtask
  // each clock phase held three cycles so the synchroniser sees every edge
  task automatic ser_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [WORD_W-1:0] w;
    w = {a, d};
    serial_select_pin <= 3'h0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serial_input_pin <= w[i];
      serial_clock_pin <= 1'b1;
      repeat (3) @(posedge clk);
      serial_clock_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    serial_select_pin <= 3'h7;
    serial_input_pin <= ~w[0];
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> test/cfg_select_chk.sv
// cfg_select_chk: port-level checks of the bus handshake and pin/strap priority
// assumes one clock domain; bound into every cfg_select instance
module cfg_select_chk
  import cfg_pkg::*;
(
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic [THERMO_W-1:0] strap_interface_select,
  input wire logic [THERMO_W-1:0] serial_select_pin,
  input wire logic                serial_clock_pin,
  input wire logic                serial_input_pin,
  input wire logic                power_down_pin,
  input wire logic                hw_reset_pin,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [WB_DW-1:0]    wb_dat_o,
  input wire logic                wb_ack_o,
  input wire cfg_t                cfg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  a_gpd_all_off: assert property (cfg_out.global_pd |-> cfg_out.chan_pd == 4'hf
    && cfg_out.ref_pd && cfg_out.pll_pd && cfg_out.outbuf_pd)
    else $error("global power-down left a block on");
  // six edges cover the two-stage synchroniser plus the output stage
  a_pin_forces_pd: assert property (power_down_pin [*6] |-> cfg_out.global_pd)
    else $error("power-down pin ignored");
  a_pat_exclusive: assert property (!(cfg_out.pat_sync && cfg_out.pat_deskew))
    else $error("sync and deskew both selected");
  a_pin_sync: assert property ((hw_reset_pin && serial_input_pin && !serial_clock_pin) [*6]
    |-> cfg_out.pat_sync)
    else $error("static data level did not select sync");
  a_pin_gain_ref: assert property ((hw_reset_pin && serial_select_pin == 3'h3) [*6]
    |-> cfg_out.gain_35db && cfg_out.ref_internal)
    else $error("select level 5/8 decoded wrongly");
  a_strap_two_ddr: assert property ((hw_reset_pin && strap_interface_select == 3'h7) [*6]
    |-> cfg_out.two_lane && cfg_out.ddr_clk)
    else $error("full interface strap decoded wrongly");
endmodule

bind cfg_select cfg_select_chk u_cfg_select_chk (.clk, .sys_rst, .strap_interface_select,
  .serial_select_pin, .serial_clock_pin, .serial_input_pin, .power_down_pin, .hw_reset_pin,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .cfg_out);

// >>> test/cfg_select_test.sv
// cfg_select_test: pin-only and register-mode priority checks for cfg_select
// assumes cfg_board_model drives the board pins; this module is the bus master
module cfg_select_test
  import cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [WB_AW-1:0]    wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [WB_DW-1:0]    wb_dat_i, wb_dat_o, q;
  logic [THERMO_W-1:0] strap_interface_select, strap_serialization_select, strap_reserved;
  logic [THERMO_W-1:0] strap_order_format_select, serial_select_pin;
  logic                serial_clock_pin, serial_input_pin, power_down_pin, hw_reset_pin;
  cfg_t                cfg_out;
  int                  n_fail, checks;
  localparam logic [THERMO_W-1:0] LV [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam logic [3:0] UP = 4'hc, MID = 4'h6, DDR = 4'hb;

  cfg_select u_cfg_select (.clk, .sys_rst, .strap_interface_select,
    .strap_serialization_select, .strap_reserved, .strap_order_format_select,
    .serial_select_pin, .serial_clock_pin, .serial_input_pin, .power_down_pin, .hw_reset_pin,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cfg_out);
  cfg_board_model u_cfg_board_model (.clk, .strap_interface_select,
    .strap_serialization_select, .strap_reserved, .strap_order_format_select,
    .serial_select_pin, .serial_clock_pin, .serial_input_pin, .power_down_pin, .hw_reset_pin);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [WB_DW-1:0] got, input logic [WB_DW-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // flags: two, ddr, 16x, rising, lsb, offset, gain, ref, sync, deskew, global pd
  task automatic cfg_is(input logic [10:0] f);
    check(32'(cfg_out), 32'({f, {7{f[0]}}}));
  endtask
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= 32'(d);
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      n_fail++;
      wrap_up();
    end
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk);
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      u_cfg_board_model.pins({LV[i], LV[0], LV[i], LV[i]}, 4'h1);
      cfg_is({UP[i], DDR[i], 2'h0, UP[i], MID[i], MID[i], UP[i], 3'h0});
      u_cfg_board_model.pins({LV[2], LV[i], LV[0], LV[0]}, 4'h1);
      cfg_is({2'h2, MID[i], UP[i], 7'h00});
    end
    for (int k = 0; k < 4; k++) begin
      u_cfg_board_model.pins({4{LV[0]}}, {1'b0, 2'(k), 1'b1});
      cfg_is(11'h200 | 11'({k == 1, k == 3, k == 2}));
    end
    u_cfg_board_model.pins({4{LV[0]}}, 4'h9);
    cfg_is(11'h201);
    $display("test pin_mode done");
    u_cfg_board_model.pins({LV[3], LV[0], LV[0], LV[3]}, 4'h0);
    cfg_is(11'h600);
    wb(1'b1, 7'h04, 11'h7ff);
    wb(1'b0, 7'h04, 11'h000);
    check(q, 32'h0);
    wb(1'b1, 7'h38, 11'h05a);
    wb(1'b0, 7'h38, 11'h000);
    check(q, 32'h5a);
    // status is read-only: the write must not disturb it
    wb(1'b1, 7'h7c, 11'h7ff);
    wb(1'b0, 7'h7c, 11'h000);
    check(q, 32'h30000);
    cfg_is(11'h600);
    u_cfg_board_model.ser_wr(ADDR_OVERRIDE, 11'h400);
    cfg_is(11'h5b0);
    wb(1'b0, 7'h34, 11'h000);
    check(q, 32'h400);
    wb(1'b1, 7'h00, 11'h021);
    repeat (4) @(posedge clk);
    cfg_is(11'h5b9);
    wb(1'b1, 7'h00, 11'h020);
    for (int p = 1; p < 3; p++) begin
      wb(1'b1, 7'h28, 11'(p << PAT_LSB));
      repeat (4) @(posedge clk);
      cfg_is(11'h5b8 | 11'(8 >> p));
    end
    wb(1'b1, 7'h28, 11'h000);
    // channel power-down bits only show while global power-down is off
    wb(1'b1, 7'h00, 11'h02a);
    repeat (4) @(posedge clk);
    check(32'(cfg_out), 32'h2dc28);
    u_cfg_board_model.pins({LV[3], LV[0], LV[0], LV[3]}, 4'h8);
    cfg_is(11'h5b9);
    u_cfg_board_model.pins({LV[3], LV[0], LV[0], LV[3]}, 4'h0);
    wb(1'b1, 7'h00, 11'h400);
    repeat (4) @(posedge clk);
    wb(1'b0, 7'h34, 11'h000);
    check(q, 32'h0);
    wb(1'b0, 7'h00, 11'h000);
    check(q, 32'h0);
    cfg_is(11'h600);
    $display("test reg_mode done");
    wrap_up();
  end
endmodule
